// ### logic/rfas_cfg.svh
`ifndef RFAS_CFG_SVH
`define RFAS_CFG_SVH

// ==========================================================
// relay command byte layout
`define RFAS_RLY_NOALARM_BIT 4
`define RFAS_RLY_NOWARN_BIT 3
`define RFAS_RLY_ACK_BIT 2
`define RFAS_RLY_MON_BIT 1
`define RFAS_RLY_SPARE_BIT 0
// rest position: no alarm, no warning, no ack, not monitoring
`define RFAS_RLY_RESET 8'h18
`define RFAS_RLY_SPARE_VAL 1'b0

// ==========================================================
// display priorities, lower number wins
`define RFAS_PRIO_BOTH 4'h1
`define RFAS_PRIO_ALARM 4'h2
`define RFAS_PRIO_WARN 4'h3
`define RFAS_PRIO_B_ACK 4'h4
`define RFAS_PRIO_A_ACK 4'h5
`define RFAS_PRIO_W_ACK 4'h6
`define RFAS_PRIO_B_CLR 4'h7
`define RFAS_PRIO_A_CLR 4'h8
`define RFAS_PRIO_W_CLR 4'h9
`define RFAS_PRIO_OK 4'hA

// ==========================================================
// timing
`define RFAS_CLK_KHZ 25000
`define RFAS_SWITCH_RESP_MS 100
`define RFAS_AUTO_BACK_MS 10000

`endif

// ### logic/rfas_pkg.sv
package rfas_pkg;

	// ==========================================================
	// level event posted per measurement
	typedef enum logic [1:0] {
		LVL_CLEAR = 2'b00,
		LVL_WARN = 2'b01,
		LVL_ALARM = 2'b11
	} rfas_lvl_e;

	// display state per input, gray along ok-alarm-ack-clear-ok
	typedef enum logic [3:0] {
		DS_OK = 4'h0,
		DS_ALARM = 4'h1,
		DS_A_ACK = 4'h3,
		DS_A_CLR = 4'h2,
		DS_WARN = 4'h6,
		DS_W_ACK = 4'h7,
		DS_W_CLR = 4'h5,
		DS_BOTH = 4'hC,
		DS_B_ACK = 4'hD,
		DS_B_CLR = 4'hF
	} rfas_disp_e;

	// combined system state reported to remote management
	typedef enum logic [2:0] {
		SYS_NORMAL = 3'h0,
		SYS_ALARM = 3'h1,
		SYS_WARN = 3'h2,
		SYS_ALARM_ACKED = 3'h3,
		SYS_WARN_ACKED = 3'h4,
		SYS_CLEAR = 3'h5
	} rfas_sys_e;

	// rf switch state, gray along normal-alarm_p-clear_p-switch_back
	typedef enum logic [2:0] {
		SW_NORMAL = 3'h0,
		SW_ALARM_P = 3'h1,
		SW_CLEAR_P = 3'h3,
		SW_SWITCH_BACK = 3'h2,
		SW_ALARM_S = 3'h6,
		SW_CLEAR_S = 3'h7,
		SW_ALARM_BOTH = 3'h4
	} rfas_sw_e;

endpackage : rfas_pkg

// ### logic/rfas_disp_if.sv
`timescale 1ns/100ps
// ==========================================================
// events into one display state machine and its state back
interface rfas_disp_if;
	logic lvl_valid;
	rfas_pkg::rfas_lvl_e lvl_kind;
	logic ack;
	logic rst;
	rfas_pkg::rfas_disp_e state;
	logic [3:0] prio;

	modport ctl (output lvl_valid, output lvl_kind, output ack, output rst,
		input state, input prio);
	modport fsm (input lvl_valid, input lvl_kind, input ack, input rst,
		output state, output prio);
endinterface : rfas_disp_if

// ### logic/rfas_disp_fsm.sv
`timescale 1ns/100ps
`include "rfas_cfg.svh"

// ==========================================================
// display and alarm state machine for one input
module rfas_disp_fsm (
	input wire logic clk_sys, // system clock
	input wire logic arst_n, // async reset, active low
	rfas_disp_if.fsm dif // events in, state out
);
	rfas_pkg::rfas_disp_e state_ff;
	rfas_pkg::rfas_disp_e nxt_state;

	// level event first; ack and reset only arrive with no level event
	always_comb begin
		nxt_state = state_ff;
		if (dif.lvl_valid) begin // see [R10]
			unique case (dif.lvl_kind)
				rfas_pkg::LVL_ALARM: begin
					unique case (state_ff)
						rfas_pkg::DS_OK, rfas_pkg::DS_A_CLR: nxt_state = rfas_pkg::DS_ALARM;
						rfas_pkg::DS_WARN, rfas_pkg::DS_W_ACK, rfas_pkg::DS_W_CLR,
						rfas_pkg::DS_B_CLR: nxt_state = rfas_pkg::DS_BOTH;
						default: nxt_state = state_ff;
					endcase
				end
				rfas_pkg::LVL_WARN: begin
					unique case (state_ff)
						rfas_pkg::DS_OK, rfas_pkg::DS_W_CLR: nxt_state = rfas_pkg::DS_WARN;
						rfas_pkg::DS_ALARM, rfas_pkg::DS_A_CLR,
						rfas_pkg::DS_B_CLR: nxt_state = rfas_pkg::DS_BOTH;
						rfas_pkg::DS_A_ACK: nxt_state = rfas_pkg::DS_B_ACK;
						default: nxt_state = state_ff;
					endcase
				end
				default: begin
					// a clear only matters once acknowledged
					unique case (state_ff)
						rfas_pkg::DS_A_ACK: nxt_state = rfas_pkg::DS_A_CLR;
						rfas_pkg::DS_B_ACK: nxt_state = rfas_pkg::DS_B_CLR;
						rfas_pkg::DS_W_ACK: nxt_state = rfas_pkg::DS_W_CLR;
						default: nxt_state = state_ff;
					endcase
				end
			endcase
		end else if (dif.ack) begin
			unique case (state_ff)
				rfas_pkg::DS_ALARM: nxt_state = rfas_pkg::DS_A_ACK;
				rfas_pkg::DS_BOTH: nxt_state = rfas_pkg::DS_B_ACK;
				rfas_pkg::DS_WARN: nxt_state = rfas_pkg::DS_W_ACK;
				default: nxt_state = state_ff;
			endcase
		end else if (dif.rst) begin
			unique case (state_ff)
				rfas_pkg::DS_A_CLR, rfas_pkg::DS_B_CLR,
				rfas_pkg::DS_W_CLR: nxt_state = rfas_pkg::DS_OK; // see [R23]
				default: nxt_state = state_ff;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= rfas_pkg::DS_OK;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// fixed priority per state
	always_comb begin
		unique case (state_ff)
			rfas_pkg::DS_BOTH: dif.prio = `RFAS_PRIO_BOTH; // see [R11]
			rfas_pkg::DS_ALARM: dif.prio = `RFAS_PRIO_ALARM;
			rfas_pkg::DS_WARN: dif.prio = `RFAS_PRIO_WARN;
			rfas_pkg::DS_B_ACK: dif.prio = `RFAS_PRIO_B_ACK;
			rfas_pkg::DS_A_ACK: dif.prio = `RFAS_PRIO_A_ACK;
			rfas_pkg::DS_W_ACK: dif.prio = `RFAS_PRIO_W_ACK;
			rfas_pkg::DS_B_CLR: dif.prio = `RFAS_PRIO_B_CLR;
			rfas_pkg::DS_A_CLR: dif.prio = `RFAS_PRIO_A_CLR;
			rfas_pkg::DS_W_CLR: dif.prio = `RFAS_PRIO_W_CLR;
			default: dif.prio = `RFAS_PRIO_OK;
		endcase
	end

	assign dif.state = state_ff;

endmodule : rfas_disp_fsm

// ### logic/rfas_ctrl.sv
`timescale 1ns/100ps
`include "rfas_cfg.svh"

// Contract
// [R01] relays follow the combined system state at once
// [R02] relays rest except alarm, warning, ack per state
// [R03] bit 4 high with no alarm, low on alarm
// [R04] bit 3 high with no warning, low on warning
// [R05] bit 2 high when acked or cleared
// [R06] bit 1 follows monitoring
// [R07] monitoring bit held in every alarm state
// [R08] each measurement posts one alarm, warning or clear
// [R09] event to switch at once, queued for display
// [R10] display takes alarm, warning, clear, ack, reset
// [R11] ten display states with priorities one to ten
// [R12] relays and state follow higher-priority input
// [R13] combined state is the remote status
// [R14] switch uses level events by source, ignores warning, ack
// [R15] switch timeout for auto switch back
// [R16] routing per switch state
// [R17] primary alarm: to secondary only if secondary good
// [R18] on secondary, secondary fails, primary good: back
// [R19] else primary back only after ack then reset
// [R20] ack and reset offered only when needed
// [R21] compare and switch on the fast path
// [R22] spare bit 0 held zero
// [R23] reset returns cleared states to ok
module rfas_ctrl #(
	parameter int LVL_W = 12, // width of a level measurement
	parameter int AUTO_BACK_CYC = `RFAS_AUTO_BACK_MS * `RFAS_CLK_KHZ // auto return delay
) (
	input wire logic clk_sys, // system clock, 25 MHz
	input wire logic arst_n, // async reset, active low
	input wire logic meas_valid, // new tuner measurement, one cycle
	input wire logic meas_src, // 0 primary, 1 secondary
	input wire logic signed [LVL_W-1:0] meas_level, // measured level
	input wire logic signed [LVL_W-1:0] warn_limit, // below this: warning
	input wire logic signed [LVL_W-1:0] alarm_limit, // below this: alarm
	input wire logic monitoring, // monitoring active
	input wire logic auto_back_en, // enable timed switch back
	input wire logic key_ack_pin, // front-panel ack key, async
	input wire logic key_reset_pin, // front-panel reset key, async
	output logic [7:0] relay_cmd, // relay command byte
	output rfas_pkg::rfas_sys_e sys_state, // combined system state
	output logic ack_offer, // ack key offered
	output logic reset_offer, // reset key offered
	output logic rf_sel_sec, // 1 routes secondary to rf out
	output rfas_pkg::rfas_disp_e disp_state_p, // primary display state
	output rfas_pkg::rfas_disp_e disp_state_s, // secondary display state
	output rfas_pkg::rfas_sw_e sw_state // switch state
);
	localparam int CNT_W = $clog2(AUTO_BACK_CYC + 1);
	localparam logic [CNT_W-1:0] AUTO_BACK_LAST = CNT_W'(AUTO_BACK_CYC - 1);

	// ==========================================================
	// front-panel key synchronisers
	logic [1:0] key_raw;
	logic [1:0] key_s1_ff;
	logic [1:0] key_s2_ff;
	logic [1:0] key_s3_ff;
	logic [1:0] key_lvl_ff;
	logic [1:0] key_rise;

	assign key_raw = {key_reset_pin, key_ack_pin};

	// three stages; the level moves only when stages two and three agree
	for (genvar k = 0; k < 2; k++) begin : g_key
		always_ff @(posedge clk_sys or negedge arst_n) begin
			if (!arst_n) begin
				key_s1_ff[k] <= 1'b0;
				key_s2_ff[k] <= 1'b0;
				key_s3_ff[k] <= 1'b0;
				key_lvl_ff[k] <= 1'b0;
			end else begin
				key_s1_ff[k] <= key_raw[k];
				key_s2_ff[k] <= key_s1_ff[k];
				key_s3_ff[k] <= key_s2_ff[k];
				if (key_s2_ff[k] == key_s3_ff[k]) begin
					key_lvl_ff[k] <= key_s3_ff[k];
				end
			end
		end
		assign key_rise[k] = (key_s2_ff[k] == key_s3_ff[k]) & key_s3_ff[k] & ~key_lvl_ff[k];
	end

	// ==========================================================
	// input processing: limit compare
	logic is_alarm;
	logic is_warn;
	rfas_pkg::rfas_lvl_e meas_kind;
	logic evt_alarm_p;
	logic evt_alarm_s;
	logic evt_clear_p;
	logic evt_clear_s;

	// exactly one event per measurement, alarm checked first
	assign is_alarm = meas_level < alarm_limit; // see [R21]
	assign is_warn = meas_level < warn_limit;
	assign meas_kind = is_alarm ? rfas_pkg::LVL_ALARM :
		(is_warn ? rfas_pkg::LVL_WARN : rfas_pkg::LVL_CLEAR); // see [R08]

	// switch events by source; a warning is no switch event at all
	assign evt_alarm_p = meas_valid & ~meas_src & is_alarm; // see [R14]
	assign evt_alarm_s = meas_valid & meas_src & is_alarm;
	assign evt_clear_p = meas_valid & ~meas_src & ~is_alarm & ~is_warn;
	assign evt_clear_s = meas_valid & meas_src & ~is_alarm & ~is_warn;

	// ==========================================================
	// display event queue, one entry per input and per key
	logic [1:0] q_valid_ff;
	rfas_pkg::rfas_lvl_e q_kind_ff [2];
	logic ack_pend_ff;
	logic rst_pend_ff;
	logic lvl_busy;
	logic ack_go;
	logic rst_go;

	// level events drain first; key events wait for a quiet cycle
	assign lvl_busy = |q_valid_ff;
	assign ack_go = ack_pend_ff & ~lvl_busy;
	assign rst_go = rst_pend_ff & ~lvl_busy & ~ack_pend_ff;

	// a newer measurement replaces an unserved one of the same input
	for (genvar i = 0; i < 2; i++) begin : g_q
		always_ff @(posedge clk_sys or negedge arst_n) begin
			if (!arst_n) begin
				q_valid_ff[i] <= 1'b0;
				q_kind_ff[i] <= rfas_pkg::LVL_CLEAR;
			end else if (meas_valid && (meas_src == 1'(i))) begin
				q_valid_ff[i] <= 1'b1; // see [R09]
				q_kind_ff[i] <= meas_kind;
			end else begin
				q_valid_ff[i] <= 1'b0;
			end
		end
	end

	// a key press arriving as it is served is kept: set wins
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ack_pend_ff <= 1'b0;
			rst_pend_ff <= 1'b0;
		end else begin
			ack_pend_ff <= key_rise[0] | (ack_pend_ff & ~ack_go);
			rst_pend_ff <= key_rise[1] | (rst_pend_ff & ~rst_go);
		end
	end

	// ==========================================================
	// display state machines, one per input
	rfas_disp_if dif [2] ();

	for (genvar i = 0; i < 2; i++) begin : g_disp
		assign dif[i].lvl_valid = q_valid_ff[i];
		assign dif[i].lvl_kind = q_kind_ff[i];
		assign dif[i].ack = ack_go;
		assign dif[i].rst = rst_go;
		rfas_disp_fsm u_disp (
			.clk_sys(clk_sys),
			.arst_n(arst_n),
			.dif(dif[i])
		);
	end

	// ==========================================================
	// combine: lower priority number wins
	rfas_pkg::rfas_disp_e win_state;
	rfas_pkg::rfas_sys_e nxt_sys;
	logic ack_need;
	logic rst_need;

	assign win_state = (dif[0].prio <= dif[1].prio) ? dif[0].state : dif[1].state; // see [R12]

	always_comb begin
		unique case (win_state)
			rfas_pkg::DS_ALARM, rfas_pkg::DS_BOTH: nxt_sys = rfas_pkg::SYS_ALARM;
			rfas_pkg::DS_WARN: nxt_sys = rfas_pkg::SYS_WARN;
			rfas_pkg::DS_A_ACK, rfas_pkg::DS_B_ACK: nxt_sys = rfas_pkg::SYS_ALARM_ACKED;
			rfas_pkg::DS_W_ACK: nxt_sys = rfas_pkg::SYS_WARN_ACKED;
			rfas_pkg::DS_A_CLR, rfas_pkg::DS_B_CLR,
			rfas_pkg::DS_W_CLR: nxt_sys = rfas_pkg::SYS_CLEAR;
			default: nxt_sys = rfas_pkg::SYS_NORMAL;
		endcase
	end

	// offers from either input's state
	assign ack_need = (dif[0].state inside {rfas_pkg::DS_ALARM, rfas_pkg::DS_BOTH,
		rfas_pkg::DS_WARN}) | (dif[1].state inside {rfas_pkg::DS_ALARM,
		rfas_pkg::DS_BOTH, rfas_pkg::DS_WARN});
	assign rst_need = (dif[0].state inside {rfas_pkg::DS_A_CLR, rfas_pkg::DS_B_CLR,
		rfas_pkg::DS_W_CLR}) | (dif[1].state inside {rfas_pkg::DS_A_CLR,
		rfas_pkg::DS_B_CLR, rfas_pkg::DS_W_CLR});

	// ==========================================================
	// relay byte and system state registers
	logic [7:0] relay_ff;
	logic [7:0] nxt_relay;
	rfas_pkg::rfas_sys_e sys_ff;
	logic ack_offer_ff;
	logic reset_offer_ff;

	always_comb begin
		nxt_relay = `RFAS_RLY_RESET; // see [R02]
		nxt_relay[`RFAS_RLY_NOALARM_BIT] = ~(nxt_sys inside {rfas_pkg::SYS_ALARM,
			rfas_pkg::SYS_ALARM_ACKED}); // see [R03]
		nxt_relay[`RFAS_RLY_NOWARN_BIT] = ~(nxt_sys inside {rfas_pkg::SYS_WARN,
			rfas_pkg::SYS_WARN_ACKED}); // see [R04]
		nxt_relay[`RFAS_RLY_ACK_BIT] = nxt_sys inside {rfas_pkg::SYS_ALARM_ACKED,
			rfas_pkg::SYS_WARN_ACKED, rfas_pkg::SYS_CLEAR}; // see [R05]
		nxt_relay[`RFAS_RLY_MON_BIT] = monitoring; // see [R06] see [R07]
		nxt_relay[`RFAS_RLY_SPARE_BIT] = `RFAS_RLY_SPARE_VAL; // see [R22]
	end

	// refreshed every cycle so relays track the state at once
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			relay_ff <= `RFAS_RLY_RESET;
			sys_ff <= rfas_pkg::SYS_NORMAL;
			ack_offer_ff <= 1'b0;
			reset_offer_ff <= 1'b0;
		end else begin
			relay_ff <= nxt_relay; // see [R01]
			sys_ff <= nxt_sys; // see [R13]
			ack_offer_ff <= ack_need; // see [R20]
			reset_offer_ff <= rst_need;
		end
	end

	// ==========================================================
	// rf switch state machine
	rfas_pkg::rfas_sw_e sw_ff;
	rfas_pkg::rfas_sw_e nxt_sw;
	logic p_good_ff;
	logic s_good_ff;
	logic ack_seen_ff;
	logic [CNT_W-1:0] tmo_cnt_ff;
	logic tmo_hit;
	logic back_ok;
	logic sel_sec_ff;

	// input health as seen by the switch: last alarm or clear, a warning leaves it unchanged
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			p_good_ff <= 1'b1;
			s_good_ff <= 1'b1;
		end else begin
			if (evt_alarm_p | evt_clear_p) begin
				p_good_ff <= evt_clear_p;
			end
			if (evt_alarm_s | evt_clear_s) begin
				s_good_ff <= evt_clear_s;
			end
		end
	end

	// operator ack must precede reset to restore primary
	assign back_ok = ack_seen_ff & key_rise[1]; // see [R19]

	// set wins, but an ack arriving as normal is reached is dropped one cycle later
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ack_seen_ff <= 1'b0;
		end else begin
			ack_seen_ff <= key_rise[0] | (ack_seen_ff & ~back_ok & (sw_ff != rfas_pkg::SW_NORMAL));
		end
	end

	// timeout only counts while waiting on secondary with primary good
	assign tmo_hit = auto_back_en & (tmo_cnt_ff == AUTO_BACK_LAST); // see [R15]

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			tmo_cnt_ff <= '0;
		end else if (sw_ff == rfas_pkg::SW_CLEAR_P && !tmo_hit) begin
			tmo_cnt_ff <= tmo_cnt_ff + CNT_W'(1);
		end else begin
			tmo_cnt_ff <= '0;
		end
	end

	// events are taken straight from the compare, not the queue
	always_comb begin
		nxt_sw = sw_ff;
		unique case (sw_ff)
			rfas_pkg::SW_NORMAL: begin
				if (evt_alarm_p) begin
					nxt_sw = s_good_ff ? rfas_pkg::SW_ALARM_P : rfas_pkg::SW_ALARM_BOTH; // see [R17]
				end else if (evt_alarm_s) begin
					nxt_sw = rfas_pkg::SW_ALARM_S;
				end
			end
			rfas_pkg::SW_ALARM_P: begin
				if (evt_alarm_s) begin
					nxt_sw = p_good_ff ? rfas_pkg::SW_SWITCH_BACK : rfas_pkg::SW_ALARM_BOTH; // see [R18]
				end else if (evt_clear_p) begin
					nxt_sw = rfas_pkg::SW_CLEAR_P;
				end
			end
			rfas_pkg::SW_CLEAR_P: begin
				if (evt_alarm_s) begin
					nxt_sw = rfas_pkg::SW_SWITCH_BACK; // see [R18]
				end else if (evt_alarm_p) begin
					nxt_sw = rfas_pkg::SW_ALARM_P;
				end else if (back_ok) begin
					nxt_sw = rfas_pkg::SW_NORMAL;
				end else if (tmo_hit) begin
					nxt_sw = rfas_pkg::SW_SWITCH_BACK;
				end
			end
			rfas_pkg::SW_ALARM_S: begin
				if (evt_alarm_p) begin
					nxt_sw = rfas_pkg::SW_ALARM_BOTH;
				end else if (evt_clear_s) begin
					nxt_sw = rfas_pkg::SW_CLEAR_S;
				end
			end
			rfas_pkg::SW_ALARM_BOTH: begin
				if (evt_clear_s && !p_good_ff) begin
					nxt_sw = rfas_pkg::SW_ALARM_P;
				end else if (evt_clear_p) begin
					nxt_sw = rfas_pkg::SW_ALARM_S;
				end
			end
			rfas_pkg::SW_CLEAR_S, rfas_pkg::SW_SWITCH_BACK: begin
				if (evt_alarm_p) begin
					nxt_sw = s_good_ff ? rfas_pkg::SW_ALARM_P : rfas_pkg::SW_ALARM_BOTH;
				end else if (evt_alarm_s) begin
					nxt_sw = rfas_pkg::SW_ALARM_S;
				end else if (back_ok) begin
					nxt_sw = rfas_pkg::SW_NORMAL; // see [R19]
				end
			end
			default: nxt_sw = rfas_pkg::SW_NORMAL;
		endcase
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sw_ff <= rfas_pkg::SW_NORMAL;
			sel_sec_ff <= 1'b0;
		end else begin
			sw_ff <= nxt_sw;
			sel_sec_ff <= (nxt_sw == rfas_pkg::SW_ALARM_P) ||
				(nxt_sw == rfas_pkg::SW_CLEAR_P); // see [R16] see [R21]
		end
	end

	// ==========================================================
	// outputs
	assign relay_cmd = relay_ff;
	assign sys_state = sys_ff;
	assign ack_offer = ack_offer_ff;
	assign reset_offer = reset_offer_ff;
	assign rf_sel_sec = sel_sec_ff;
	assign disp_state_p = dif[0].state;
	assign disp_state_s = dif[1].state;
	assign sw_state = sw_ff;

endmodule : rfas_ctrl

// ### tb/rfas_ctrl_properties.sv
`timescale 1ns/100ps
// ==========================================
// port checks of the alarm and switch block
module rfas_ctrl_properties #(
	parameter int LVL_W = 12 // level width
) (
	input wire logic clk_sys, // clock
	input wire logic arst_n, // reset
	input wire logic meas_valid, // strobe
	input wire logic meas_src, // source
	input wire logic signed [LVL_W-1:0] meas_level, // level
	input wire logic signed [LVL_W-1:0] warn_limit, // warn limit
	input wire logic signed [LVL_W-1:0] alarm_limit, // alarm limit
	input wire logic monitoring, // monitoring
	input wire logic [7:0] relay_cmd, // relays
	input wire rfas_pkg::rfas_sys_e sys_state, // system state
	input wire logic ack_offer, // ack offer
	input wire logic rf_sel_sec, // routing
	input wire rfas_pkg::rfas_disp_e disp_state_p, // primary
	input wire rfas_pkg::rfas_disp_e disp_state_s, // secondary
	input wire rfas_pkg::rfas_sw_e sw_state // switch
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);

	// priority of a display state, lower wins
	function automatic logic [3:0] prio(rfas_pkg::rfas_disp_e d);
		case (d)
			rfas_pkg::DS_BOTH: prio = 4'h1;
			rfas_pkg::DS_ALARM: prio = 4'h2;
			rfas_pkg::DS_WARN: prio = 4'h3;
			rfas_pkg::DS_B_ACK: prio = 4'h4;
			rfas_pkg::DS_A_ACK: prio = 4'h5;
			rfas_pkg::DS_W_ACK: prio = 4'h6;
			rfas_pkg::DS_B_CLR: prio = 4'h7;
			rfas_pkg::DS_A_CLR: prio = 4'h8;
			rfas_pkg::DS_W_CLR: prio = 4'h9;
			default: prio = 4'hA;
		endcase
	endfunction : prio

	// system state of the winning input
	function automatic rfas_pkg::rfas_sys_e sys_of(rfas_pkg::rfas_disp_e a,
		rfas_pkg::rfas_disp_e b);
		rfas_pkg::rfas_disp_e d;
		d = (prio(a) <= prio(b)) ? a : b;
		case (d)
			rfas_pkg::DS_BOTH, rfas_pkg::DS_ALARM: sys_of = rfas_pkg::SYS_ALARM;
			rfas_pkg::DS_WARN: sys_of = rfas_pkg::SYS_WARN;
			rfas_pkg::DS_B_ACK, rfas_pkg::DS_A_ACK: sys_of = rfas_pkg::SYS_ALARM_ACKED;
			rfas_pkg::DS_W_ACK: sys_of = rfas_pkg::SYS_WARN_ACKED;
			rfas_pkg::DS_OK: sys_of = rfas_pkg::SYS_NORMAL;
			default: sys_of = rfas_pkg::SYS_CLEAR;
		endcase
	endfunction : sys_of

	// primary alarm measurement, and one with no follower
	sequence s_prim_alarm;
		meas_valid && !meas_src && (meas_level < alarm_limit);
	endsequence
	sequence s_lone_alarm;
		s_prim_alarm ##1 !meas_valid;
	endsequence

	// ==========================================
	// relay byte, routing, system state and ack offer
	a_spare_zero: assert property (relay_cmd[0] == 1'b0 && relay_cmd[7:5] == 3'h0)
		else $error("spare relay bits not zero");
	a_alarm_bit: assert property (relay_cmd[4] == !(sys_state inside
		{rfas_pkg::SYS_ALARM, rfas_pkg::SYS_ALARM_ACKED}))
		else $error("alarm relay bit wrong");
	a_warn_bit: assert property (relay_cmd[3] == !(sys_state inside
		{rfas_pkg::SYS_WARN, rfas_pkg::SYS_WARN_ACKED}))
		else $error("warning relay bit wrong");
	a_ack_bit: assert property (relay_cmd[2] == (sys_state inside {rfas_pkg::SYS_CLEAR,
		rfas_pkg::SYS_ALARM_ACKED, rfas_pkg::SYS_WARN_ACKED}))
		else $error("ack relay bit wrong");
	a_mon_bit: assert property ($stable(monitoring)[*3] |-> relay_cmd[1] == monitoring)
		else $error("monitoring bit wrong");
	a_route_map: assert property (rf_sel_sec == (sw_state inside
		{rfas_pkg::SW_ALARM_P, rfas_pkg::SW_CLEAR_P}))
		else $error("routing wrong");
	a_sys_follow: assert property (sys_state ==
		sys_of($past(disp_state_p), $past(disp_state_s)))
		else $error("system state wrong");
	a_ack_offer: assert property (ack_offer == (sys_state inside
		{rfas_pkg::SYS_ALARM, rfas_pkg::SYS_WARN}))
		else $error("ack offer wrong");
	// ==========================================
	// event handling
	a_alarm_event: assert property (s_lone_alarm |=> disp_state_p inside {rfas_pkg::DS_ALARM,
		rfas_pkg::DS_BOTH, rfas_pkg::DS_A_ACK, rfas_pkg::DS_B_ACK})
		else $error("display missed alarm");
	a_alarm_switch: assert property ((sw_state == rfas_pkg::SW_NORMAL) ##0 s_prim_alarm
		|=> sw_state inside {rfas_pkg::SW_ALARM_P, rfas_pkg::SW_ALARM_BOTH})
		else $error("switch missed alarm");
	a_warn_ignored: assert property (meas_valid && meas_level >= alarm_limit
		&& meas_level < warn_limit && sw_state inside {rfas_pkg::SW_NORMAL,
		rfas_pkg::SW_ALARM_P} |=> $stable(sw_state))
		else $error("warning moved switch");
endmodule : rfas_ctrl_properties

// ### tb/rfas_tuner_model.sv
`timescale 1ns/100ps
// ==========================================
// tuner measurement source and front-panel keys
module rfas_tuner_model #(
	parameter int LVL_W = 12 // level width
) (
	input wire logic clk_sys, // clock
	output logic meas_valid, // strobe
	output logic meas_src, // source
	output logic signed [LVL_W-1:0] meas_level, // level
	output logic key_ack_pin, // ack key
	output logic key_reset_pin // reset key
);
	// keys released, no strobe at start
	initial begin
		meas_valid = 1'b0;
		meas_src = 1'b0;
		meas_level = '0;
		key_ack_pin = 1'b0;
		key_reset_pin = 1'b0;
	end

	// one-cycle strobe; qualifiers inverted after it
	task measure(input logic s, input logic signed [LVL_W-1:0] lvl);
		@(negedge clk_sys);
		meas_valid = 1'b1;
		meas_src = s;
		meas_level = lvl;
		@(negedge clk_sys);
		meas_valid = 1'b0;
		meas_src = ~s;
		meas_level = ~lvl;
	endtask : measure

	// key held past the synchroniser, then released before the next press
	task press(input logic rst);
		@(negedge clk_sys);
		if (rst) begin
			key_reset_pin = 1'b1;
		end else begin
			key_ack_pin = 1'b1;
		end
		repeat (8) @(negedge clk_sys);
		key_ack_pin = 1'b0;
		key_reset_pin = 1'b0;
		repeat (8) @(negedge clk_sys);
	endtask : press
endmodule : rfas_tuner_model

// ### tb/rfas_ctrl_tb_top.sv
`timescale 1ns/100ps
module rfas_ctrl_tb_top;
	localparam int LVL_W = 12;
	localparam int BACK_CYC = 20;
	localparam logic signed [LVL_W-1:0] LV_A = 12'h0080;
	localparam logic signed [LVL_W-1:0] LV_W = 12'h0100; // exactly alarm limit
	localparam logic signed [LVL_W-1:0] LV_C = 12'h0200; // exactly warn limit
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic monitoring = 1'b0;
	logic auto_back_en = 1'b0;
	logic signed [LVL_W-1:0] warn_limit = 12'h0200;
	logic signed [LVL_W-1:0] alarm_limit = 12'h0100;
	logic meas_valid, meas_src, key_ack_pin, key_reset_pin;
	logic signed [LVL_W-1:0] meas_level;
	logic [7:0] relay_cmd;
	rfas_pkg::rfas_sys_e sys_state;
	logic ack_offer, reset_offer, rf_sel_sec;
	rfas_pkg::rfas_disp_e disp_state_p, disp_state_s;
	rfas_pkg::rfas_sw_e sw_state;
	int errors = 0;
	int compares = 0;

	// ==========================================
	// clock, far side and design
	always #20 clk_sys = ~clk_sys;

	rfas_tuner_model #(.LVL_W(LVL_W)) u_rfas_tuner_model (.clk_sys(clk_sys),
		.meas_valid(meas_valid), .meas_src(meas_src), .meas_level(meas_level),
		.key_ack_pin(key_ack_pin), .key_reset_pin(key_reset_pin));

	rfas_ctrl #(.LVL_W(LVL_W), .AUTO_BACK_CYC(BACK_CYC)) u_rfas_ctrl (.clk_sys(clk_sys),
		.arst_n(arst_n), .meas_valid(meas_valid), .meas_src(meas_src),
		.meas_level(meas_level), .warn_limit(warn_limit), .alarm_limit(alarm_limit),
		.monitoring(monitoring), .auto_back_en(auto_back_en), .key_ack_pin(key_ack_pin),
		.key_reset_pin(key_reset_pin), .relay_cmd(relay_cmd), .sys_state(sys_state),
		.ack_offer(ack_offer), .reset_offer(reset_offer), .rf_sel_sec(rf_sel_sec),
		.disp_state_p(disp_state_p), .disp_state_s(disp_state_s), .sw_state(sw_state));

	// ==========================================
	// helpers
	task ck(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : ck

	task wt(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : wt

	task end_of_test;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_of_test

	// watchdog, run needs well under a thousand cycles
	initial begin
		#(40 * 3000);
		errors++;
		end_of_test;
	end

	// ==========================================
	// main sequence
	initial begin
		repeat (6) @(posedge clk_sys);
		ck("relay rst", relay_cmd, 8'h18);
		ck("sw rst", sw_state, rfas_pkg::SW_NORMAL);
		@(negedge clk_sys);
		arst_n = 1'b1;
		monitoring = 1'b1;
		wt(3);
		ck("relay mon", relay_cmd, 8'h1A);
		// secondary warning on the alarm boundary, then primary loss
		u_rfas_tuner_model.measure(1'b1, LV_W);
		wt(4);
		ck("disp s", disp_state_s, rfas_pkg::DS_WARN);
		ck("sys", sys_state, rfas_pkg::SYS_WARN);
		ck("relay", relay_cmd, 8'h12);
		ck("sw", sw_state, rfas_pkg::SW_NORMAL);
		ck("ack offer", ack_offer, 8'h01);
		u_rfas_tuner_model.measure(1'b0, LV_A);
		wt(4);
		ck("rf sel", rf_sel_sec, 8'h01);
		ck("sw", sw_state, rfas_pkg::SW_ALARM_P);
		ck("disp p", disp_state_p, rfas_pkg::DS_ALARM);
		ck("sys", sys_state, rfas_pkg::SYS_ALARM);
		ck("relay", relay_cmd, 8'h0A);
		u_rfas_tuner_model.press(1'b0);
		ck("sys", sys_state, rfas_pkg::SYS_ALARM_ACKED);
		ck("relay", relay_cmd, 8'h0E);
		ck("ack offer", ack_offer, 8'h00);
		ck("reset offer", reset_offer, 8'h00);
		// both inputs back on the warn boundary
		u_rfas_tuner_model.measure(1'b1, LV_C);
		u_rfas_tuner_model.measure(1'b0, LV_C);
		wt(4);
		ck("sys", sys_state, rfas_pkg::SYS_CLEAR);
		ck("relay", relay_cmd, 8'h1E);
		ck("sw", sw_state, rfas_pkg::SW_CLEAR_P);
		ck("reset offer", reset_offer, 8'h01);
		u_rfas_tuner_model.press(1'b1);
		ck("disp p", disp_state_p, rfas_pkg::DS_OK);
		ck("disp s", disp_state_s, rfas_pkg::DS_OK);
		ck("relay", relay_cmd, 8'h1A);
		ck("rf sel", rf_sel_sec, 8'h00);
		// timed switch back from Clear-P
		auto_back_en = 1'b1;
		u_rfas_tuner_model.measure(1'b0, LV_A);
		u_rfas_tuner_model.measure(1'b0, LV_C);
		wt(1);
		ck("sw", sw_state, rfas_pkg::SW_CLEAR_P);
		wt(BACK_CYC + 10);
		ck("sw", sw_state, rfas_pkg::SW_SWITCH_BACK);
		ck("rf sel", rf_sel_sec, 8'h00);
		// secondary fails while carrying the output
		auto_back_en = 1'b0;
		u_rfas_tuner_model.measure(1'b0, LV_A);
		wt(1);
		ck("rf sel", rf_sel_sec, 8'h01);
		u_rfas_tuner_model.measure(1'b0, LV_C);
		u_rfas_tuner_model.measure(1'b1, LV_A);
		wt(1);
		ck("rf sel", rf_sel_sec, 8'h00);
		// primary loss with secondary bad stays on primary
		u_rfas_tuner_model.measure(1'b0, LV_A);
		wt(4);
		ck("rf sel", rf_sel_sec, 8'h00);
		ck("alarm bit", relay_cmd[4], 8'h00);
		monitoring = 1'b0;
		wt(3);
		ck("mon bit", relay_cmd[1], 8'h00);
		end_of_test;
	end
endmodule : rfas_ctrl_tb_top

bind rfas_ctrl rfas_ctrl_properties #(.LVL_W(LVL_W)) u_rfas_ctrl_properties (
	.clk_sys(clk_sys), .arst_n(arst_n), .meas_valid(meas_valid), .meas_src(meas_src),
	.meas_level(meas_level), .warn_limit(warn_limit), .alarm_limit(alarm_limit),
	.monitoring(monitoring), .relay_cmd(relay_cmd), .sys_state(sys_state),
	.ack_offer(ack_offer), .rf_sel_sec(rf_sel_sec), .disp_state_p(disp_state_p),
	.disp_state_s(disp_state_s), .sw_state(sw_state));
